// ### tb_top.sv
// self-checking bench for the uart host bus interface
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, srst, select_a_hi, select_b_hi, select_c_lo, read_strobe_hi, read_strobe_lo;
  logic write_strobe_hi, write_strobe_lo, addr_latch_strobe_n, hoe, host_data_oe, drive_disable_n;
  logic wr_event, rd_event, idle_pat;
  logic [2:0] reg_select, event_addr;
  logic [7:0] hd, host_data_in, host_data_out;
  logic [63:0] reg_contents;
  logic [7:0] shadow [8];
  int errors, total_checks;

  // bus wire: host, else device, else a level flipping each cycle (no pull)
  assign host_data_in = hoe ? hd : host_data_oe ? host_data_out : {8{idle_pat}};
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // released bus level, one process owns it
  initial begin
    idle_pat = 1'h0;
    forever @(negedge mclk) idle_pat = ~idle_pat;
  end

  uhbi_host_model host (.mclk, .select_a_hi, .select_b_hi, .select_c_lo, .reg_select, .read_strobe_hi,
    .read_strobe_lo, .write_strobe_hi, .write_strobe_lo, .addr_latch_strobe_n, .hd, .hoe);
  uhbi_top DUT (.mclk, .srst, .select_a_hi, .select_b_hi, .select_c_lo, .reg_select, .read_strobe_hi,
    .read_strobe_lo, .write_strobe_hi, .write_strobe_lo, .addr_latch_strobe_n, .host_data_in,
    .host_data_out, .host_data_oe, .drive_disable_n, .wr_event, .rd_event, .event_addr, .reg_contents);

  function automatic logic sel_hit(input logic [2:0] s);
    return s === 3'h6;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // every register against the shadow, so a stray write shows anywhere
  task automatic chk_all();
    for (int i = 0; i < 8; i++) chk(reg_contents[i*8 +: 8], shadow[i]);
  endtask
  task automatic do_write(input logic [2:0] s, input logic [2:0] a, input logic [7:0] d, input logic hi, input int n);
    host.set_sel(s, a);
    host.strobe_on(1'h1, hi, d);
    repeat (n) @(negedge mclk);
    host.strobe_off();
    @(negedge mclk);
    chk(wr_event, sel_hit(s));
    if (sel_hit(s)) begin
      shadow[a] = d;
      chk(event_addr, a);
    end
    chk_all();
  endtask
  task automatic do_read(input logic [2:0] s, input logic [2:0] a, input logic hi, input int n);
    host.set_sel(s, a);
    host.strobe_on(1'h0, hi, 8'h00);
    #1;
    chk(host_data_oe, sel_hit(s));
    chk(drive_disable_n, !sel_hit(s));
    repeat (n) @(negedge mclk);
    if (sel_hit(s)) begin
      chk(host_data_in, shadow[a]);
      chk(host_data_in[0], shadow[a][0]);
    end
    host.strobe_off();
    #1;
    chk(host_data_oe, 1'h0);
    @(negedge mclk);
    chk(rd_event, sel_hit(s));
  endtask

  // watchdog, far beyond the expected run length
  initial begin
    #400000;
    errors++;
    stop_test();
  end
  initial begin
    srst = 1'h1;
    void'($urandom(32'hADB0));
    errors = 0;
    total_checks = 0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    srst = 1'h0;
    chk(host_data_oe, 1'h0);
    chk_all();
    // walking bit per register, both polarities of each strobe
    for (int i = 0; i < 8; i++) do_write(3'h6, i[2:0], 8'h01 << i, i[0], i % 3 + 1);
    for (int i = 0; i < 8; i++) do_read(3'h6, i[2:0], i[1], 2);
    // every select combination; only one selects the device
    for (int s = 0; s < 8; s++) begin
      do_write(s[2:0], 3'h7, {s[2:0], 5'h15}, s[0], 1);
      do_read(s[2:0], 3'h7, s[1], 2);
    end
    // latched selects and address outlive live pins that deselect
    host.set_sel(3'h6, 3'h5);
    host.set_as(1'h1);
    host.set_sel(3'h1, 3'h2);
    host.strobe_on(1'h1, 1'h0, 8'hC3);
    @(negedge mclk);
    host.strobe_off();
    @(negedge mclk);
    shadow[5] = 8'hC3;
    chk(wr_event, 1'h1);
    chk_all();
    // latched read while the live pins still deselect
    host.strobe_on(1'h0, 1'h1, 8'h00);
    #1;
    chk(host_data_oe, 1'h1);
    repeat (2) @(negedge mclk);
    chk(host_data_in, 8'hC3);
    host.strobe_off();
    @(negedge mclk);
    chk(rd_event, 1'h1);
    host.set_as(1'h0);
    // random traffic with the odd deselected access
    for (int k = 0; k < 40; k++) begin
      logic [2:0] s, a;
      s = ($urandom % 4 == 0) ? 3'($urandom) : 3'h6;
      a = 3'($urandom);
      do_write(s, a, 8'($urandom), 1'($urandom), 1 + $urandom % 3);
      do_read(s, a, 1'($urandom), 2 + $urandom % 2);
    end
    // reset in mid-run clears the store, then a first access right after release
    srst = 1'h1;
    repeat (2) @(negedge mclk);
    srst = 1'h0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    chk(host_data_oe, 1'h0);
    chk_all();
    do_write(3'h6, 3'h3, 8'hA5, 1'h0, 1);
    do_read(3'h6, 3'h3, 1'h0, 2);
    stop_test();
  end
endmodule
`default_nettype wire

// ### uhbi_host_model.sv
// host cpu model that drives the uart host bus pins
`timescale 1ns/1ps
`default_nettype none
module uhbi_host_model (
  input wire logic mclk, // bus clock
  output logic select_a_hi, // chip select a
  output logic select_b_hi, // chip select b
  output logic select_c_lo, // chip select c, low asserts
  output logic [2:0] reg_select, // register address
  output logic read_strobe_hi, // read strobe, high
  output logic read_strobe_lo, // read strobe, low
  output logic write_strobe_hi, // write strobe, high
  output logic write_strobe_lo, // write strobe, low
  output logic addr_latch_strobe_n, // address strobe
  output logic [7:0] hd, // data the host drives
  output logic hoe // host drives the bus
);
  // idle: selects asserted, strobes inactive, latch transparent
  initial begin
    {select_a_hi, select_b_hi, select_c_lo} = 3'h6;
    reg_select = 3'h0;
    {read_strobe_hi, read_strobe_lo, write_strobe_hi, write_strobe_lo} = 4'h5;
    addr_latch_strobe_n = 1'h0;
    hd = 8'h00;
    hoe = 1'h0;
  end
  // selects held until the next call, so an access sees them stable
  task automatic set_sel(input logic [2:0] s, input logic [2:0] a);
    @(negedge mclk);
    {select_a_hi, select_b_hi, select_c_lo} = s;
    reg_select = a;
  endtask
  task automatic set_as(input logic v);
    @(negedge mclk);
    addr_latch_strobe_n = v;
  endtask
  // one strobe on; the other polarity stays inactive
  task automatic strobe_on(input logic wr, input logic hi, input logic [7:0] d);
    @(negedge mclk);
    hd = d;
    hoe = wr;
    write_strobe_hi = wr & hi;
    write_strobe_lo = !(wr & !hi);
    read_strobe_hi = !wr & hi;
    read_strobe_lo = !(!wr & !hi);
  endtask
  // strobes off and bus released together
  task automatic strobe_off();
    @(negedge mclk);
    {read_strobe_hi, read_strobe_lo, write_strobe_hi, write_strobe_lo} = 4'h5;
    hoe = 1'h0;
  endtask
endmodule
`default_nettype wire

// ### uhbi_pkg.sv
// shared constants and types for the uart host bus interface
package uhbi_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int NUM_REGS = 8;

  // pin levels that count as asserted, and the idle (transparent) address strobe level
  localparam logic SEL_A_ON = 1'h1;
  localparam logic SEL_B_ON = 1'h1;
  localparam logic SEL_C_ON = 1'h0;
  localparam logic STROBE_HI_ON = 1'h1;
  localparam logic STROBE_LO_ON = 1'h0;
  localparam logic LATCH_IDLE = 1'h0;
  localparam logic DRIVE_DISABLE_N_READING = 1'h0;

  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] ADDR_RESET = 3'h0;

  // selects and register address as one bundle, latched or live
  typedef struct packed {
    logic sel_a;
    logic sel_b;
    logic sel_c_n;
    logic [ADDR_W-1:0] addr;
  } uhbi_sel_type;

  localparam uhbi_sel_type SEL_RESET = '{sel_a: 1'h0, sel_b: 1'h0, sel_c_n: 1'h1, addr: ADDR_RESET};

  // access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } uhbi_state_type;

endpackage

// ### uhbi_regstore.sv
// register store: flop array written by the host port, read by index
`timescale 1ns/1ps
`default_nettype none
module uhbi_regstore #(
  parameter int DATA_W = uhbi_pkg::DATA_W,
  parameter int ADDR_W = uhbi_pkg::ADDR_W,
  parameter int NUM_REGS = uhbi_pkg::NUM_REGS
) (
  input wire logic mclk, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic wr_en, // one-cycle store pulse
  input wire logic [ADDR_W-1:0] wr_addr, // register written
  input wire logic [DATA_W-1:0] wr_data, // value written
  input wire logic [ADDR_W-1:0] rd_addr, // register read
  output logic [DATA_W-1:0] rd_data, // combinational read value
  output logic [NUM_REGS*DATA_W-1:0] contents // every register, register 0 lowest
);

  logic [DATA_W-1:0] store_reg [NUM_REGS];
  logic [DATA_W-1:0] store_next [NUM_REGS];

  // one flop word per register, each with its own next-value logic
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_word
    always_comb begin
      store_next[i] = store_reg[i];
      if (wr_en && (wr_addr == ADDR_W'(i))) begin
        store_next[i] = wr_data;
      end
    end

    always_ff @(posedge mclk) begin
      if (srst) begin
        store_reg[i] <= uhbi_pkg::REG_RESET;
      end else begin
        store_reg[i] <= store_next[i];
      end
    end

    assign contents[i*DATA_W +: DATA_W] = store_reg[i];
  end

  // read path, bit 0 of each word is its least significant bit
  assign rd_data = store_reg[rd_addr];

endmodule
`default_nettype wire

// ### uhbi_top.sv
// uart host bus interface: selects, strobes, address latch and data bus
// Summary of operation
// RULE1: selected when both high selects high, third low
// RULE2: third chip select is active low
// RULE3: read when either read strobe asserted
// RULE4: both write strobes move data in alike
// RULE5: host holds unused high write strobe low
// RULE6: address strobe rise latches selects and address
// RULE7: address strobe held low passes inputs directly
// RULE8: three select bits choose the register
// RULE9: eight-bit two-way tri-state data bus
// RULE10: data bit 0 is least significant
// RULE11: write stores bus data into selected register
// RULE12: drive disable low while host reads
// RULE13: bus driven only during selected read
`timescale 1ns/1ps
`default_nettype none
module uhbi_top #(
  parameter int DATA_W = uhbi_pkg::DATA_W,
  parameter int ADDR_W = uhbi_pkg::ADDR_W,
  parameter int NUM_REGS = uhbi_pkg::NUM_REGS
) (
  input wire logic mclk, // system clock, 50 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic select_a_hi, // chip select, active high
  input wire logic select_b_hi, // chip select, active high
  input wire logic select_c_lo, // chip select, active low
  input wire logic [ADDR_W-1:0] reg_select, // register address
  input wire logic read_strobe_hi, // read strobe, active high
  input wire logic read_strobe_lo, // read strobe, active low
  input wire logic write_strobe_hi, // write strobe, active high
  input wire logic write_strobe_lo, // write strobe, active low
  input wire logic addr_latch_strobe_n, // address strobe, rising edge latches
  input wire logic [DATA_W-1:0] host_data_in, // data bus, pin level
  output logic [DATA_W-1:0] host_data_out, // data bus, driven value
  output logic host_data_oe, // data bus output enable, high drives
  output logic drive_disable_n, // low while host reads
  output logic wr_event, // one-cycle pulse when a register is stored
  output logic rd_event, // one-cycle pulse when a read ends
  output logic [ADDR_W-1:0] event_addr, // register of the last event
  output logic [NUM_REGS*DATA_W-1:0] reg_contents // all registers, register 0 lowest
);

  // decode of the select bundle, used for live and latched forms
  function automatic logic sel_match(input uhbi_pkg::uhbi_sel_type s);
    sel_match = (s.sel_a == uhbi_pkg::SEL_A_ON) && (s.sel_b == uhbi_pkg::SEL_B_ON)
      && (s.sel_c_n == uhbi_pkg::SEL_C_ON);
  endfunction

  uhbi_pkg::uhbi_sel_type live_sel;
  uhbi_pkg::uhbi_sel_type eff_sel;
  uhbi_pkg::uhbi_sel_type latch_reg, latch_next;
  logic as_prev_reg, as_prev_next;
  logic as_rise;
  logic selected;
  logic rd_req;
  logic wr_req;

  uhbi_pkg::uhbi_state_type state_reg, state_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic wr_pulse_reg, wr_pulse_next;
  logic rd_pulse_reg, rd_pulse_next;
  logic [DATA_W-1:0] store_rd_data;

  // live pin bundle
  assign live_sel = '{sel_a: select_a_hi, sel_b: select_b_hi, sel_c_n: select_c_lo, addr: reg_select};
  assign as_rise = addr_latch_strobe_n && !as_prev_reg; // [RULE6]

  // address latch: capture on rising strobe, hold while high
  always_comb begin
    as_prev_next = addr_latch_strobe_n;
    latch_next = latch_reg;
    if (as_rise) begin
      latch_next = live_sel; // [RULE6]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      as_prev_reg <= uhbi_pkg::LATCH_IDLE;
      latch_reg <= uhbi_pkg::SEL_RESET;
    end else begin
      as_prev_reg <= as_prev_next;
      latch_reg <= latch_next;
    end
  end

  // strobe low means transparent; in the rising cycle the live pins are what gets latched
  assign eff_sel = (addr_latch_strobe_n == uhbi_pkg::LATCH_IDLE || as_rise) ? live_sel : latch_reg; // [RULE7]
  assign selected = sel_match(eff_sel); // [RULE1] [RULE2]
  // either polarity counts; the host ties the unused one inactive
  assign rd_req = (read_strobe_hi == uhbi_pkg::STROBE_HI_ON) || (read_strobe_lo == uhbi_pkg::STROBE_LO_ON); // [RULE3]
  assign wr_req = (write_strobe_hi == uhbi_pkg::STROBE_HI_ON)
    || (write_strobe_lo == uhbi_pkg::STROBE_LO_ON); // [RULE4] [RULE5]

  // access sequencer: data is taken on the last strobe cycle, stored as the strobe drops,
  // so a host that settles data late in the strobe is still caught
  always_comb begin
    state_next = state_reg;
    wdata_next = wdata_reg;
    addr_next = addr_reg;
    wr_pulse_next = 1'h0;
    rd_pulse_next = 1'h0;
    unique case (state_reg)
      uhbi_pkg::ST_IDLE: begin
        if (selected && wr_req) begin
          state_next = uhbi_pkg::ST_WRITE;
          wdata_next = host_data_in;
          addr_next = eff_sel.addr; // [RULE8]
        end else if (selected && rd_req) begin
          state_next = uhbi_pkg::ST_READ;
          addr_next = eff_sel.addr;
        end
      end
      uhbi_pkg::ST_WRITE: begin
        if (selected && wr_req) begin
          wdata_next = host_data_in; // [RULE4]
          addr_next = eff_sel.addr;
        end else begin
          state_next = uhbi_pkg::ST_IDLE;
          wr_pulse_next = 1'h1; // [RULE11]
        end
      end
      uhbi_pkg::ST_READ: begin
        if (!(selected && rd_req)) begin
          state_next = uhbi_pkg::ST_IDLE;
          rd_pulse_next = 1'h1;
        end
      end
      default: begin
        state_next = uhbi_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= uhbi_pkg::ST_IDLE;
      wdata_reg <= uhbi_pkg::REG_RESET;
      addr_reg <= uhbi_pkg::ADDR_RESET;
      wr_pulse_reg <= 1'h0;
      rd_pulse_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      wdata_reg <= wdata_next;
      addr_reg <= addr_next;
      wr_pulse_reg <= wr_pulse_next;
      rd_pulse_reg <= rd_pulse_next;
    end
  end

  uhbi_regstore #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .NUM_REGS(NUM_REGS)) u_store (
    .mclk(mclk),
    .srst(srst),
    .wr_en(wr_pulse_next),
    .wr_addr(addr_reg),
    .wr_data(wdata_reg),
    .rd_addr(eff_sel.addr),
    .rd_data(store_rd_data),
    .contents(reg_contents)
  );

  // read data flop follows the addressed register every cycle, one cycle behind
  always_comb begin
    dout_next = store_rd_data; // [RULE8] [RULE10]
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      dout_reg <= uhbi_pkg::REG_RESET;
    end else begin
      dout_reg <= dout_next;
    end
  end

  // enable is combinational so the bus is released the moment the read drops
  assign host_data_out = dout_reg; // [RULE9]
  assign host_data_oe = selected && rd_req && !wr_req && !srst; // [RULE13]
  assign drive_disable_n = host_data_oe ? uhbi_pkg::DRIVE_DISABLE_N_READING : !uhbi_pkg::DRIVE_DISABLE_N_READING; // [RULE12]
  assign wr_event = wr_pulse_reg;
  assign rd_event = rd_pulse_reg;
  assign event_addr = addr_reg;

  // checks
  // pin-level decode written out apart from the logic, checked while the latch is transparent
  property p_oe_decode;
    @(posedge mclk) disable iff (srst)
    !addr_latch_strobe_n |-> host_data_oe == (select_a_hi && select_b_hi && !select_c_lo
      && (read_strobe_hi || !read_strobe_lo) && !write_strobe_hi && write_strobe_lo);
  endproperty
  a_oe_decode: assert property (p_oe_decode) else $error("bus enable does not match read decode"); // [RULE13]

  property p_cs_c_blocks;
    @(posedge mclk) disable iff (srst)
    (eff_sel.sel_c_n != uhbi_pkg::SEL_C_ON) |-> !host_data_oe;
  endproperty
  a_cs_c_blocks: assert property (p_cs_c_blocks) else $error("bus driven with low-active select off"); // [RULE2]

  property p_sel_ab;
    @(posedge mclk) disable iff (srst)
    (!eff_sel.sel_a || !eff_sel.sel_b) |-> !host_data_oe && (state_next == uhbi_pkg::ST_IDLE || state_reg != uhbi_pkg::ST_IDLE);
  endproperty
  a_sel_ab: assert property (p_sel_ab) else $error("access taken without both high selects"); // [RULE1]

  property p_rd_hi;
    @(posedge mclk) disable iff (srst)
    selected && read_strobe_hi && !wr_req |-> host_data_oe && !drive_disable_n;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("high read strobe did not start a read"); // [RULE3]

  property p_drive_disable_n;
    @(posedge mclk) disable iff (srst)
    drive_disable_n == !host_data_oe;
  endproperty
  a_drive_disable_n: assert property (p_drive_disable_n) else $error("drive disable not low during read"); // [RULE12]

  property p_latch_capture;
    @(posedge mclk) disable iff (srst)
    as_rise ##1 addr_latch_strobe_n |-> eff_sel == $past(live_sel);
  endproperty
  a_latch_capture: assert property (p_latch_capture) else $error("address strobe rise did not latch selects"); // [RULE6]

  property p_transparent;
    @(posedge mclk) disable iff (srst)
    !addr_latch_strobe_n |-> eff_sel == live_sel;
  endproperty
  a_transparent: assert property (p_transparent) else $error("low address strobe not transparent"); // [RULE7]

  property p_write_store;
    @(posedge mclk) disable iff (srst)
    (state_reg == uhbi_pkg::ST_WRITE && !(selected && wr_req)) |->
      ##1 wr_event ##0 reg_contents[addr_reg*DATA_W +: DATA_W] == wdata_reg;
  endproperty
  a_write_store: assert property (p_write_store) else $error("write did not store bus data"); // [RULE11] [RULE4]

  property p_read_data;
    @(posedge mclk) disable iff (srst)
    host_data_oe && $past(host_data_oe) && $stable(eff_sel.addr) && !$past(wr_pulse_next)
      |-> host_data_out == reg_contents[eff_sel.addr*DATA_W +: DATA_W];
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data is not the addressed register"); // [RULE8] [RULE9]

  property p_cov_read;
    @(posedge mclk) disable iff (srst)
    host_data_oe ##2 rd_event;
  endproperty
  c_cov_read: cover property (p_cov_read);

  property p_cov_write;
    @(posedge mclk) disable iff (srst)
    (state_reg == uhbi_pkg::ST_WRITE) ##1 wr_event;
  endproperty
  c_cov_write: cover property (p_cov_write);

  property p_cov_latched_read;
    @(posedge mclk) disable iff (srst)
    as_rise ##[1:20] (addr_latch_strobe_n && host_data_oe);
  endproperty
  c_cov_latched_read: cover property (p_cov_latched_read);

endmodule
`default_nettype wire
